// ===== ccrs_regs.svh
// Constants of the core register set: reset values, stack page, flag bits.
// Included by the register set module.
`ifndef CCRS_REGS_SVH
`define CCRS_REGS_SVH
`define CCRS_ACC_RST 8'h00
`define CCRS_IDX_RST 8'h00
`define CCRS_SP_RST 8'hFF
`define CCRS_PC_RST 16'h0000
`define CCRS_FLAGS_RST 8'h04
`define CCRS_STACK_PAGE0 8'h00
`define CCRS_STACK_PAGE1 8'h01
`define CCRS_BREAK_BIT 4
`define CCRS_MODE_ADDR 16'h003B
`define CCRS_MODE_PAGE_BIT 2
`define CCRS_MODE_RST 8'h00
`endif

// ===== ccrs_pkg.sv
// Types of the core register set.
// Assumes the constants header alongside.
package ccrs_pkg;
  typedef enum logic [3:0] {
    CCRS_OP_NONE = 4'b0000,
    CCRS_OP_PUSH_ACC = 4'b0001,
    CCRS_OP_POP_ACC = 4'b0010,
    CCRS_OP_PUSH_FLAGS = 4'b0011,
    CCRS_OP_POP_FLAGS = 4'b0100,
    CCRS_OP_PUSH_BRK = 4'b0101,
    CCRS_OP_FAST_SET = 4'b0110,
    CCRS_OP_SLOW = 4'b0111,
    CCRS_OP_HALT_OSC = 4'b1000,
    CCRS_OP_WAIT = 4'b1001,
    CCRS_OP_PRODUCT = 4'b1010,
    CCRS_OP_DIVIDE = 4'b1011
  } ccrs_op_e;
endpackage : ccrs_pkg

// ===== ccrs_core_register_set.sv
// Programmer-visible register set of an 8-bit core with stack push and pop.
// Assumes a decoder issuing one op per cycle and a memory port with same-cycle read data.
// Registers update on every rising clock edge; reset is synchronous.
// Function
// - 8-bit accumulator is main operand and result register.
// - Indexed address is operand plus first index register.
// - Second indexed address is operand plus second index register.
// - 8-bit stack pointer saves registers on calls and interrupts.
// - Stack address low byte is stack pointer on push, stack pointer plus one on pop.
// - Stack address high byte is 00 or 01 by page selection bit.
// - 16-bit program counter of high and low byte registers.
// - Fast-set and slow instructions are not implemented.
// - Oscillator-stop, wait, multiply and divide are supported.
// - Push and pop instructions for accumulator and flags.
// - Page selection bit lives in core mode register at fixed address.
// - Break push stores flags with break bit one; live bit reads zero.
`timescale 1ns/1ns
`include "ccrs_regs.svh"
module ccrs_core_register_set (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register loads from the datapath
  input wire logic i_acc_we,
  input wire logic [7:0] i_acc_d,
  input wire logic i_idx1_we,
  input wire logic [7:0] i_idx1_d,
  input wire logic i_idx2_we,
  input wire logic [7:0] i_idx2_d,
  input wire logic i_sp_we,
  input wire logic [7:0] i_sp_d,
  input wire logic i_flags_we,
  input wire logic [7:0] i_flags_d,
  input wire logic i_pc_we,
  input wire logic [15:0] i_pc_d,
  input wire logic i_pc_inc,
  // Core mode register special-function write
  input wire logic i_sfr_we,
  input wire logic [15:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_d,
  // Operation and address formation
  input wire ccrs_pkg::ccrs_op_e i_op,
  input wire logic [7:0] i_operand,
  input wire logic [7:0] i_mem_rdata,
  // Register values
  output logic [7:0] o_acc,
  output logic [7:0] o_idx1,
  output logic [7:0] o_idx2,
  output logic [7:0] o_sp,
  output logic [7:0] o_flags,
  output logic [7:0] o_core_mode_reg,
  output logic [7:0] o_counter_high_byte,
  output logic [7:0] o_counter_low_byte,
  output logic [15:0] o_program_counter,
  // Addresses and stack memory port
  output logic [15:0] o_idx1_addr,
  output logic [15:0] o_idx2_addr,
  output logic [15:0] o_stack_addr,
  output logic o_stack_we,
  output logic o_stack_re,
  output logic [7:0] o_stack_wdata,
  // Op support
  output logic o_op_supported,
  output logic o_op_illegal
);
  import ccrs_pkg::*;

  localparam logic [15:0] PC_RST = `CCRS_PC_RST;

  // Architectural registers
  logic [7:0] acc_r;
  logic [1:0][7:0] idx_r;
  logic [7:0] sp_r;
  logic [7:0] flags_r;
  logic [7:0] mode_r;
  logic [7:0] pc_hi_r;
  logic [7:0] pc_lo_r;

  // Next values
  logic [7:0] acc_nxt;
  logic [1:0][7:0] idx_nxt;
  logic [7:0] sp_nxt;
  logic [7:0] flags_nxt;
  logic [7:0] mode_nxt;
  logic [7:0] pc_hi_nxt;
  logic [7:0] pc_lo_nxt;

  // Decode and address helpers
  logic is_push;
  logic is_pop;
  logic mode_hit;
  logic pc_carry;
  logic [7:0] sp_step;
  logic [7:0] page_hi;
  logic [1:0] idx_we;
  logic [1:0][7:0] idx_d;
  logic [1:0][15:0] idx_addr;

  function automatic logic op_push(input ccrs_op_e op);
    op_push = (op == CCRS_OP_PUSH_ACC) ||
      (op == CCRS_OP_PUSH_FLAGS) ||
      (op == CCRS_OP_PUSH_BRK);
  endfunction : op_push

  function automatic logic op_pop(input ccrs_op_e op);
    op_pop = (op == CCRS_OP_POP_ACC) || (op == CCRS_OP_POP_FLAGS);
  endfunction : op_pop

  function automatic logic [15:0] index_sum(input logic [7:0] operand, input logic [7:0] base);
    index_sum = {8'h00, operand} + {8'h00, base};
  endfunction : index_sum

  function automatic logic [7:0] strip_break(input logic [7:0] value);
    strip_break = value & ~(8'h01 << `CCRS_BREAK_BIT);
  endfunction : strip_break

  // Op class decode, shared by pointer and strobes
  assign is_push = op_push(i_op);
  assign is_pop = op_pop(i_op);

  // Pop reads the byte above the pointer, so address uses the pre-incremented value
  // Pointer wraps inside its page by plain 8-bit arithmetic
  always_comb begin
    sp_step = sp_r;
    if (is_push) begin
      sp_step = sp_r - 8'h01;
    end else if (is_pop) begin
      sp_step = sp_r + 8'h01;
    end
  end

  // Page byte is 00 or 01; other mode bits never reach the address
  assign page_hi = mode_r[`CCRS_MODE_PAGE_BIT] ? `CCRS_STACK_PAGE1 : `CCRS_STACK_PAGE0;
  assign o_stack_addr = {page_hi, (is_pop ? sp_step : sp_r)};
  assign o_stack_we = is_push;
  assign o_stack_re = is_pop;

  // Write data; idle value is zero so the bus stays quiet
  always_comb begin
    case (i_op)
      CCRS_OP_PUSH_ACC: o_stack_wdata = acc_r;
      CCRS_OP_PUSH_FLAGS: o_stack_wdata = flags_r;
      CCRS_OP_PUSH_BRK: o_stack_wdata = flags_r | (8'h01 << `CCRS_BREAK_BIT);
      default: o_stack_wdata = 8'h00;
    endcase
  end

  // Accumulator; pop data wins over a datapath load in the same cycle
  always_comb begin
    acc_nxt = acc_r;
    if (i_op == CCRS_OP_POP_ACC) begin
      acc_nxt = i_mem_rdata;
    end else if (i_acc_we) begin
      acc_nxt = i_acc_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_r <= `CCRS_ACC_RST;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // Index registers, one loop body per register
  assign idx_we = {i_idx2_we, i_idx1_we};
  assign idx_d = {i_idx2_d, i_idx1_d};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_idx
      always_comb begin
        idx_nxt[g] = idx_r[g];
        if (idx_we[g]) begin
          idx_nxt[g] = idx_d[g];
        end
      end

      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          idx_r[g] <= `CCRS_IDX_RST;
        end else begin
          idx_r[g] <= idx_nxt[g];
        end
      end

      // Operand is zero-extended, so a carry reaches the high byte
      assign idx_addr[g] = index_sum(i_operand, idx_r[g]);
    end
  endgenerate

  assign o_idx1_addr = idx_addr[0];
  assign o_idx2_addr = idx_addr[1];

  // Stack pointer; stack traffic wins over a direct load
  always_comb begin
    sp_nxt = sp_r;
    if (is_push || is_pop) begin
      sp_nxt = sp_step;
    end else if (i_sp_we) begin
      sp_nxt = i_sp_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sp_r <= `CCRS_SP_RST;
    end else begin
      sp_r <= sp_nxt;
    end
  end

  // Flags; break bit is never stored, so it always reads zero
  always_comb begin
    flags_nxt = flags_r;
    if (i_op == CCRS_OP_POP_FLAGS) begin
      flags_nxt = strip_break(i_mem_rdata);
    end else if (i_flags_we) begin
      flags_nxt = strip_break(i_flags_d);
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags_r <= `CCRS_FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // Core mode register; only its own address writes it
  assign mode_hit = i_sfr_we && (i_sfr_addr == `CCRS_MODE_ADDR);

  always_comb begin
    mode_nxt = mode_r;
    if (mode_hit) begin
      mode_nxt = i_sfr_d;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mode_r <= `CCRS_MODE_RST;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // Program counter as two byte registers; low byte carry steps the high byte
  always_comb begin
    pc_lo_nxt = pc_lo_r;
    pc_hi_nxt = pc_hi_r;
    pc_carry = 1'b0;
    if (i_pc_we) begin
      pc_lo_nxt = i_pc_d[7:0];
      pc_hi_nxt = i_pc_d[15:8];
    end else if (i_pc_inc) begin
      {pc_carry, pc_lo_nxt} = {1'b0, pc_lo_r} + 9'h001;
      pc_hi_nxt = pc_hi_r + {7'h00, pc_carry};
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pc_lo_r <= PC_RST[7:0];
    end else begin
      pc_lo_r <= pc_lo_nxt;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pc_hi_r <= PC_RST[15:8];
    end else begin
      pc_hi_r <= pc_hi_nxt;
    end
  end

  // Instruction availability
  always_comb begin
    case (i_op)
      CCRS_OP_FAST_SET, CCRS_OP_SLOW: begin
        o_op_supported = 1'b0;
        o_op_illegal = 1'b1;
      end
      CCRS_OP_HALT_OSC, CCRS_OP_WAIT, CCRS_OP_PRODUCT, CCRS_OP_DIVIDE: begin
        o_op_supported = 1'b1;
        o_op_illegal = 1'b0;
      end
      CCRS_OP_NONE: begin
        o_op_supported = 1'b0;
        o_op_illegal = 1'b0;
      end
      // Push, pop and unlisted codes fall to default and read as supported
      default: begin
        o_op_supported = 1'b1;
        o_op_illegal = 1'b0;
      end
    endcase
  end

  // Registered values straight to the ports
  assign o_acc = acc_r;
  assign o_idx1 = idx_r[0];
  assign o_idx2 = idx_r[1];
  assign o_sp = sp_r;
  assign o_flags = flags_r;
  assign o_core_mode_reg = mode_r;
  assign o_program_counter = {pc_hi_r, pc_lo_r};
  assign o_counter_high_byte = pc_hi_r;
  assign o_counter_low_byte = pc_lo_r;
endmodule : ccrs_core_register_set

// ===== ccrs_monitor.sv
// Port checker of the core register set.
// Bound onto the register set; sees its ports only.
`timescale 1ns/1ns
module ccrs_monitor
  import ccrs_pkg::*;
(
  // Clock, reset, requests
  input wire logic i_clock,
  input wire logic i_rst,
  input wire ccrs_pkg::ccrs_op_e i_op,
  input wire logic [7:0] i_operand,
  input wire logic [7:0] i_mem_rdata,
  // Observed outputs
  input wire logic [7:0] o_acc,
  input wire logic [7:0] o_idx1,
  input wire logic [7:0] o_idx2,
  input wire logic [7:0] o_sp,
  input wire logic [7:0] o_flags,
  input wire logic [7:0] o_core_mode_reg,
  input wire logic [15:0] o_idx1_addr,
  input wire logic [15:0] o_idx2_addr,
  input wire logic [15:0] o_stack_addr,
  input wire logic o_stack_we,
  input wire logic o_stack_re,
  input wire logic [7:0] o_stack_wdata,
  input wire logic o_op_illegal,
  input wire logic o_op_supported,
  input wire logic [7:0] o_counter_high_byte,
  input wire logic [7:0] o_counter_low_byte,
  input wire logic [15:0] o_program_counter
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  logic [7:0] pg;
  assign pg = {7'h00, o_core_mode_reg[2]};
  sequence acc_got;
    o_acc == $past(i_mem_rdata);
  endsequence
  push_addr_a: assert property (o_stack_we |-> o_stack_addr == {pg, o_sp})
    else $error("push address wrong");
  pop_addr_a: assert property (o_stack_re |-> o_stack_addr == {pg, o_sp + 8'h01})
    else $error("pop address wrong");
  sp_dec_a: assert property (o_stack_we |=> o_sp == $past(o_sp) - 8'h01)
    else $error("pointer not lowered");
  pop_acc_a: assert property (i_op == CCRS_OP_POP_ACC |-> o_stack_re ##1 acc_got)
    else $error("pop lost data");
  idx_one_a: assert property (o_idx1_addr == {8'h00, i_operand} + {8'h00, o_idx1})
    else $error("index one sum wrong");
  idx_two_a: assert property (o_idx2_addr == {8'h00, i_operand} + {8'h00, o_idx2})
    else $error("index two sum wrong");
  brk_push_a: assert property (i_op == CCRS_OP_PUSH_BRK |-> o_stack_wdata == (o_flags | 8'h10) && !o_flags[4])
    else $error("break push wrong");
  op_illegal_a: assert property (o_op_illegal == (i_op inside {CCRS_OP_FAST_SET, CCRS_OP_SLOW}))
    else $error("illegal flag wrong");
  op_supported_a: assert property (o_op_supported == !(i_op inside {CCRS_OP_NONE, CCRS_OP_FAST_SET, CCRS_OP_SLOW}))
    else $error("supported flag wrong");
  pc_bytes_a: assert property ({o_counter_high_byte, o_counter_low_byte} == o_program_counter)
    else $error("counter bytes wrong");
endmodule : ccrs_monitor
bind ccrs_core_register_set ccrs_monitor i_ccrs_monitor (.i_clock, .i_rst, .i_op, .i_operand, .i_mem_rdata,
  .o_acc, .o_idx1, .o_idx2, .o_sp, .o_flags, .o_core_mode_reg, .o_idx1_addr, .o_idx2_addr,
  .o_stack_addr, .o_stack_we, .o_stack_re, .o_stack_wdata, .o_op_illegal, .o_op_supported,
  .o_counter_high_byte, .o_counter_low_byte, .o_program_counter);

// ===== ccrs_core_register_set_test.sv
// Random op bench of the core register set, queued scoreboard.
// Assumes package, header, design and checker alongside.
`timescale 1ns/1ns
module ccrs_core_register_set_test;
  import ccrs_pkg::*;
  logic i_clock = 0, i_rst = 1, i_acc_we = 0, i_idx1_we = 0, i_idx2_we = 0, i_sp_we = 0;
  logic i_flags_we = 0, i_pc_we = 0, i_pc_inc = 0, i_sfr_we = 0, pp;
  logic [7:0] i_acc_d = '0, i_idx1_d = '0, i_idx2_d = '0, i_sp_d = '0, i_flags_d = '0;
  logic [7:0] i_sfr_d = '0, i_operand = '0, i_mem_rdata = '0, o_acc, o_sp, o_flags;
  logic [15:0] i_pc_d = '0, i_sfr_addr = '0, o_program_counter;
  ccrs_op_e i_op = CCRS_OP_NONE, op;
  logic [39:0] q[$];
  logic [39:0] nx, e;
  logic [7:0] acc = 8'h00, sp = 8'hFF, fl = 8'h04;
  logic [15:0] pc = 16'h0000;
  logic [31:0] r = 32'h0CF36FBF;
  int fail_count = 0, n_tests = 0, cyc = 0;
  ccrs_core_register_set i_ccrs_core_register_set (.*, .o_idx1(), .o_idx2(), .o_core_mode_reg(),
    .o_counter_high_byte(), .o_counter_low_byte(), .o_idx1_addr(), .o_idx2_addr(), .o_stack_addr(),
    .o_stack_we(), .o_stack_re(), .o_stack_wdata(), .o_op_supported(), .o_op_illegal());
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task chk(input logic [39:0] s, input logic [39:0] x);
    n_tests++;
    if (s !== x) begin
      fail_count++;
      $display("[FAIL] regs exp %h got %h", x, s);
    end
  endtask : chk
  task final_report;
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  initial forever #4 i_clock = ~i_clock;
  // Hang guard, well above the 2000 op run
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      final_report();
    end
  end
  always @(negedge i_clock) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      chk({o_acc, o_sp, o_flags, o_program_counter}, e);
    end
  end
  initial begin
    repeat (3) @(posedge i_clock);
    i_rst <= 1'b0;
    nx = {acc, sp, fl, pc};
    repeat (2000) begin
      @(posedge i_clock);
      q.push_back(nx);
      r = xs(r);
      op = ccrs_op_e'(r[3:0] % 4'hC);
      pp = op inside {[CCRS_OP_PUSH_ACC:CCRS_OP_PUSH_BRK]};
      i_op <= op;
      // Accumulator and flags loads kept off push and pop; pointer load stays on to be refused
      i_acc_we <= r[4] & !pp;
      i_flags_we <= r[6] & !pp;
      i_sp_we <= r[5];
      i_sfr_we <= r[7];
      i_sfr_addr <= r[8] ? 16'h003B : {r[31:24], 8'h3A};
      i_pc_we <= r[9];
      i_pc_inc <= r[10];
      i_idx1_we <= r[11];
      i_idx2_we <= r[12];
      {i_acc_d, i_sp_d, i_flags_d, i_sfr_d, i_mem_rdata, i_idx1_d, i_idx2_d} <= {7{r[23:16]}};
      i_operand <= r[31:24];
      i_pc_d <= r[31:16];
      if (op inside {CCRS_OP_PUSH_ACC, CCRS_OP_PUSH_FLAGS, CCRS_OP_PUSH_BRK}) sp = sp - 8'h01;
      else if (pp) sp = sp + 8'h01;
      else if (r[5]) sp = r[23:16];
      if (op == CCRS_OP_POP_ACC || (r[4] && !pp)) acc = r[23:16];
      if (op == CCRS_OP_POP_FLAGS || (r[6] && !pp)) fl = r[23:16] & 8'hEF;
      pc = r[9] ? r[31:16] : pc + {15'h0000, r[10]};
      nx = {acc, sp, fl, pc};
    end
    @(posedge i_clock);
    q.push_back(nx);
    repeat (2) @(posedge i_clock);
    final_report();
  end
endmodule : ccrs_core_register_set_test
